// *** src/slp_oh_monitor_regs.sv ***
// apb register bank for sonet line and path overhead monitoring and insertion
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: count line parity errors, twenty bits, readable
// RULE2: poll write latches counts, restarts accumulation
// RULE3: master address write loads all meters
// RULE4: count line far end errors, twenty bits
// RULE5: same poll latches and restarts far count
// RULE6: far count spread over three byte registers
// RULE7: remote defect control sends 110 in K2
// RULE8: software writes zero to reserved bits
// RULE9: corruption bit inverts transmitted B2 bytes
// RULE10: alarm status shows remote, ais, pointer loss
// RULE11: path parity and path far error events set flags
// RULE12: alarm change in either direction sets flag
// RULE13: accepted label change sets bit seven
// RULE14: reading event status clears all flags
// RULE15: enabled error events raise interrupt
// RULE16: enabled alarm or label changes raise interrupt
// RULE17: label accepted after three equal frames
// RULE18: path parity count low byte readable
// RULE19: line parity count over three byte registers
// RULE20: path parity high byte latched likewise
// RULE21: interrupt is OR of enabled flags, held
module slp_oh_monitor_regs
(
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire slp_pkg::slp_rx_ev_t  rx_ev,
   input  wire slp_pkg::slp_tx_byte_t tx_in,
   output var slp_pkg::slp_tx_byte_t tx_out,
   output logic                      meter_load,
   output logic                      irq
);
   import slp_pkg::*;

   typedef struct packed {
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      logic [19:0]  line_par_acc;
      logic [19:0]  line_par_hold;
      logic [19:0]  line_far_acc;
      logic [19:0]  line_far_hold;
      logic [15:0]  path_par_acc;
      logic [15:0]  path_par_hold;
      logic [6:0]   tx_ctrl;
      logic         corrupt;
      logic [7:0]   alarm_rsv;
      logic [7:0]   enable;
      logic [7:0]   flags;
      logic [2:0]   alarm_prev;
      logic [7:0]   label;
      logic [7:0]   label_cand;
      logic [1:0]   label_cnt;
      logic         meter_load;
      logic         irq;
      slp_tx_byte_t tx;
   } slp_state_t;

   slp_state_t s_q;
   slp_state_t s_d;

   // saturating accumulate; a restart keeps a coincident event
   function automatic logic [19:0] acc20(input logic [19:0] acc,
                                         input logic        inc,
                                         input logic        restart);
      logic [19:0] base;
      base = restart ? RST_CNT : acc;
      if (inc && (base != 20'hfffff))
      begin
         base = base + 20'h00001;
      end
      return base;
   endfunction

   logic [5:0]  idx;
   logic        addr_ok;
   logic        xfer_done;
   logic        wr_done;
   logic        rd_done;
   logic [7:0]  rd_byte;
   logic        mapped;
   logic        line_poll;
   logic        path_poll;
   logic        master_poll;
   logic [2:0]  alarm_now;
   logic [7:0]  flag_set;
   logic        read_clear;

   assign idx         = paddr[7:2];
   assign addr_ok     = (paddr[1:0] == 2'b00);
   assign xfer_done   = psel && penable && s_q.pready;
   assign wr_done     = xfer_done && pwrite && !s_q.pslverr;
   assign rd_done     = xfer_done && !pwrite && !s_q.pslverr;
   assign alarm_now   = {rx_ev.ptr_loss, rx_ev.ais, rx_ev.remote};
   assign master_poll = wr_done && (idx == IDX_MASTER_LOAD);
   assign line_poll   = master_poll ||                               // RULE3
                        (wr_done && (idx >= IDX_LINE_PAR_LOW) && (idx <= IDX_LINE_FAR_HIGH));
   assign path_poll   = master_poll ||                               // RULE3
                        (wr_done && ((idx == IDX_PATH_PAR_LOW) || (idx == IDX_PATH_PAR_HIGH)));
   assign read_clear  = rd_done && (idx == IDX_EVENT_STATUS);

   // read mux; unmapped indices answer with an error
   always_comb
   begin
      rd_byte = RST_BYTE;
      mapped  = 1'b1;
      case (idx)
         IDX_MASTER_LOAD:   rd_byte = RST_BYTE;
         IDX_LINE_PAR_LOW:  rd_byte = s_q.line_par_hold[7:0];        // RULE19
         IDX_LINE_PAR_MID:  rd_byte = s_q.line_par_hold[15:8];       // RULE19
         IDX_LINE_PAR_HIGH: rd_byte = {4'h0, s_q.line_par_hold[19:16]}; // RULE19
         IDX_LINE_FAR_LOW:  rd_byte = s_q.line_far_hold[7:0];        // RULE6
         IDX_LINE_FAR_MID:  rd_byte = s_q.line_far_hold[15:8];       // RULE6
         IDX_LINE_FAR_HIGH: rd_byte = {4'h0, s_q.line_far_hold[19:16]}; // RULE6
         IDX_TX_CTRL:       rd_byte = {1'b0, s_q.tx_ctrl};
         IDX_TX_DIAG:       rd_byte = {7'h00, s_q.corrupt};
         IDX_ALARM_STATUS:                                           // RULE10
         begin
            rd_byte = s_q.alarm_rsv;
            rd_byte[BIT_REMOTE]   = rx_ev.remote;
            rd_byte[BIT_AIS]      = rx_ev.ais;
            rd_byte[BIT_PTR_LOSS] = rx_ev.ptr_loss;
         end
         IDX_EVENT_STATUS:  rd_byte = s_q.flags;
         IDX_EVENT_ENABLE:  rd_byte = s_q.enable;
         IDX_LABEL:         rd_byte = s_q.label;
         IDX_PATH_PAR_LOW:  rd_byte = s_q.path_par_hold[7:0];        // RULE18
         IDX_PATH_PAR_HIGH: rd_byte = s_q.path_par_hold[15:8];       // RULE20
         default:           mapped  = 1'b0;
      endcase
   end

   always_comb
   begin
      s_d = s_q;
      flag_set = 8'h00;

      // apb: one wait state so read data leaves a flop
      s_d.pready = 1'b0;
      if (psel && penable && !s_q.pready)
      begin
         s_d.pready  = 1'b1;
         s_d.pslverr = !(mapped && addr_ok);
         // a refused read answers zero, whatever the index decodes to
         s_d.prdata  = (pwrite || !(mapped && addr_ok)) ? 32'h00000000 : {24'h000000, rd_byte};
      end
      else if (xfer_done)
      begin
         s_d.pslverr = 1'b0;
      end

      if (wr_done)
      begin
         case (idx)
            IDX_TX_CTRL:      s_d.tx_ctrl   = pwdata[6:0];           // RULE8
            IDX_TX_DIAG:      s_d.corrupt   = pwdata[0];
            IDX_ALARM_STATUS: s_d.alarm_rsv = pwdata[7:0] & ALARM_RSV_MASK;
            IDX_EVENT_ENABLE: s_d.enable    = pwdata[7:0];
            default:          s_d.enable    = s_q.enable;
         endcase
      end

      // line meters: poll moves count to holding and restarts
      if (line_poll)
      begin
         s_d.line_par_hold = s_q.line_par_acc;                        // RULE2
         s_d.line_far_hold = s_q.line_far_acc;                        // RULE5
      end
      s_d.line_par_acc = acc20(s_q.line_par_acc, rx_ev.line_par_err, line_poll); // RULE1
      s_d.line_far_acc = acc20(s_q.line_far_acc, rx_ev.line_far_err, line_poll); // RULE4

      // path parity meter, saturating at all ones
      if (path_poll)
      begin
         s_d.path_par_hold = s_q.path_par_acc;                        // RULE20
         s_d.path_par_acc  = {15'h0, rx_ev.path_par_err};
      end
      else if (rx_ev.path_par_err && (s_q.path_par_acc != 16'hffff))
      begin
         s_d.path_par_acc = s_q.path_par_acc + 16'h0001;
      end

      // label persistence: three equal frames before acceptance
      if (rx_ev.frame)
      begin
         if (rx_ev.label == s_q.label)
         begin
            s_d.label_cnt = 2'd0;
         end
         else if ((rx_ev.label == s_q.label_cand) && (s_q.label_cnt != 2'd0))
         begin
            if (s_q.label_cnt == LABEL_FRAMES - 2'd1)
            begin
               s_d.label     = rx_ev.label;                           // RULE17
               s_d.label_cnt = 2'd0;
               flag_set[BIT_LABEL] = 1'b1;                            // RULE13
            end
            else
            begin
               s_d.label_cnt = s_q.label_cnt + 2'd1;
            end
         end
         else
         begin
            s_d.label_cand = rx_ev.label;
            s_d.label_cnt  = 2'd1;
         end
      end

      // event flags; a set in the clearing cycle survives
      s_d.alarm_prev = alarm_now;
      flag_set[BIT_FAR_ERR]  = rx_ev.path_far_err;                    // RULE11
      flag_set[BIT_PAR_ERR]  = rx_ev.path_par_err;                    // RULE11
      flag_set[BIT_REMOTE]   = alarm_now[0] ^ s_q.alarm_prev[0];      // RULE12
      flag_set[BIT_AIS]      = alarm_now[1] ^ s_q.alarm_prev[1];      // RULE12
      flag_set[BIT_PTR_LOSS] = alarm_now[2] ^ s_q.alarm_prev[2];      // RULE12
      s_d.flags = (read_clear ? 8'h00 : s_q.flags) | flag_set;        // RULE14
      s_d.irq   = |(s_d.flags & s_d.enable);                          // RULE15 RULE16 RULE21

      s_d.meter_load = master_poll;                                   // RULE3

      // transmit overhead insertion
      s_d.tx = tx_in;
      if (tx_in.valid && tx_in.k2_slot && s_q.tx_ctrl[0])
      begin
         s_d.tx.data[2:0] = RDI_CODE;                                 // RULE7
      end
      if (tx_in.valid && tx_in.b2_slot && s_q.corrupt)
      begin
         s_d.tx.data = ~tx_in.data;                                   // RULE9
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata     = s_q.prdata;
   assign pready     = s_q.pready;
   assign pslverr    = s_q.pslverr;
   assign tx_out     = s_q.tx;
   assign meter_load = s_q.meter_load;
   assign irq        = s_q.irq;

   // checks
   sequence line_poll_seq;
      line_poll;
   endsequence

   sequence three_frames_seq;
      $changed(s_q.label);
   endsequence

   a_poll_latch: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
      line_poll_seq |=> (s_q.line_par_hold == $past(s_q.line_par_acc))
                        && (s_q.line_par_acc == 20'($past(rx_ev.line_par_err))))
      else $error("line parity poll did not latch and restart");

   a_far_restart: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
      line_poll_seq |=> (s_q.line_far_hold == $past(s_q.line_far_acc))
                        && (s_q.line_far_acc == 20'($past(rx_ev.line_far_err))))
      else $error("far error poll did not latch and restart");

   a_master_load: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
      master_poll |=> meter_load && (s_q.path_par_hold == $past(s_q.path_par_acc)))
      else $error("master write did not load meters");

   a_rdi_insert: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
      (tx_in.valid && tx_in.k2_slot && !tx_in.b2_slot && s_q.tx_ctrl[0])
      |=> (tx_out.data[2:0] == RDI_CODE))
      else $error("remote defect code missing from K2");

   a_b2_invert: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
      (tx_in.valid && tx_in.b2_slot && s_q.corrupt) |=> (tx_out.data == ~$past(tx_in.data)))
      else $error("B2 byte not inverted");

   a_status_view: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
      ($rose(pready) && !pwrite && (idx == IDX_ALARM_STATUS) && !pslverr)
      |-> (prdata[5] == $past(rx_ev.ptr_loss)) && (prdata[3] == $past(rx_ev.ais))
          && (prdata[2] == $past(rx_ev.remote)))
      else $error("alarm status read wrong");

   a_event_flag: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
      rx_ev.path_par_err |=> s_q.flags[BIT_PAR_ERR] ##0 (irq || !s_q.enable[BIT_PAR_ERR]))
      else $error("parity event flag not set");

   a_alarm_edge: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
      (alarm_now[1] != s_q.alarm_prev[1]) |=> s_q.flags[BIT_AIS])
      else $error("ais change not flagged");

   a_read_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
      (read_clear && (flag_set == 8'h00)) |=> (s_q.flags == 8'h00) && !irq)
      else $error("status read did not clear flags");

   a_irq_or: assert property (@(posedge clk) disable iff (sys_rst) // RULE21
      irq == |(s_q.flags & s_q.enable))
      else $error("interrupt differs from enabled flags");

   a_label_persist: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
      three_frames_seq |-> $past(rx_ev.frame) && ($past(s_q.label_cnt) == 2'd2)
                           && s_q.flags[BIT_LABEL])
      else $error("label accepted without three frames");

endmodule

`default_nettype wire

// *** inc/slp_pkg.sv ***
// constants and carrier types for the line and path overhead monitor registers
package slp_pkg;
   // register indices; bus byte address is four times the index
   localparam logic [5:0] IDX_MASTER_LOAD   = 6'h00;
   localparam logic [5:0] IDX_LINE_PAR_LOW  = 6'h1a;
   localparam logic [5:0] IDX_LINE_PAR_MID  = 6'h1b;
   localparam logic [5:0] IDX_LINE_PAR_HIGH = 6'h1c;
   localparam logic [5:0] IDX_LINE_FAR_LOW  = 6'h1d;
   localparam logic [5:0] IDX_LINE_FAR_MID  = 6'h1e;
   localparam logic [5:0] IDX_LINE_FAR_HIGH = 6'h1f;
   localparam logic [5:0] IDX_TX_CTRL       = 6'h20;
   localparam logic [5:0] IDX_TX_DIAG       = 6'h21;
   localparam logic [5:0] IDX_ALARM_STATUS  = 6'h30;
   localparam logic [5:0] IDX_EVENT_STATUS  = 6'h31;
   localparam logic [5:0] IDX_EVENT_ENABLE  = 6'h33;
   localparam logic [5:0] IDX_LABEL         = 6'h37;
   localparam logic [5:0] IDX_PATH_PAR_LOW  = 6'h38;
   localparam logic [5:0] IDX_PATH_PAR_HIGH = 6'h39;
   // field positions
   localparam int BIT_FAR_ERR    = 0;
   localparam int BIT_PAR_ERR    = 1;
   localparam int BIT_REMOTE     = 2;
   localparam int BIT_AIS        = 3;
   localparam int BIT_PTR_LOSS   = 5;
   localparam int BIT_LABEL      = 7;
   localparam logic [7:0] ALARM_RSV_MASK = 8'h81;
   localparam logic [2:0] RDI_CODE       = 3'b110;
   // reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [19:0] RST_CNT  = 20'h00000;
   // poll transfer must finish inside this time
   localparam int POLL_TIME_NS   = 7000;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int POLL_MAX_CYC   = POLL_TIME_NS / CLK_PERIOD_NS;
   localparam logic [1:0] LABEL_FRAMES = 2'd3;

   typedef struct packed {
      logic       line_par_err;
      logic       line_far_err;
      logic       path_par_err;
      logic       path_far_err;
      logic       remote;
      logic       ais;
      logic       ptr_loss;
      logic       frame;
      logic [7:0] label;
   } slp_rx_ev_t;

   typedef struct packed {
      logic       valid;
      logic       k2_slot;
      logic       b2_slot;
      logic [7:0] data;
   } slp_tx_byte_t;
endpackage

// *** tb/slp_dp_model.sv ***
// far-side model: receive overhead events and the transmit byte stream
`timescale 1ns/1ps
`default_nettype none
module slp_dp_model
(
   input  wire logic             clk,
   output var slp_pkg::slp_rx_ev_t   rx_ev,
   output var slp_pkg::slp_tx_byte_t tx_in
);
   import slp_pkg::*;
   logic [7:0] cnt_q = 8'h00;
   initial rx_ev = '0;
   initial tx_in = '0;
   // free stream; k2 and b2 slots never coincide so each change is seen alone
   always @(posedge clk)
   begin
      cnt_q <= cnt_q + 8'h01;
      tx_in <= '{1'b1, cnt_q[2:0] == 3'h3, cnt_q[2:0] == 3'h5, cnt_q ^ 8'h5a};
   end
   // m = {line parity, line far, path parity, path far}, one pulse per count
   task automatic ev(input logic [3:0] m, input int n);
      repeat (n)
      begin
         @(posedge clk);
         {rx_ev.line_par_err, rx_ev.line_far_err, rx_ev.path_par_err, rx_ev.path_far_err} <= m;
         @(posedge clk);
         {rx_ev.line_par_err, rx_ev.line_far_err, rx_ev.path_par_err, rx_ev.path_far_err} <= 4'h0;
      end
   endtask
   task automatic alarm(input logic [2:0] a);
      @(posedge clk);
      {rx_ev.remote, rx_ev.ais, rx_ev.ptr_loss} <= a;
   endtask
   task automatic frame(input logic [7:0] l);
      @(posedge clk);
      rx_ev.frame <= 1'b1;
      rx_ev.label <= l;
      @(posedge clk);
      rx_ev.frame <= 1'b0;
      // label is only meaningful with frame; show the inverse so stale use fails
      rx_ev.label <= ~l;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the overhead monitor register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
   import slp_pkg::*;
   logic         clk = 1'b0;
   logic         sys_rst, psel, penable, pwrite, pready, pslverr, meter_load, irq, err;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rdata;
   slp_rx_ev_t   rx_ev;
   slp_tx_byte_t tx_in, tx_out, tx_q, tx_e;
   int           n_mismatch = 0;
   int           n_tests = 0;
   int           n_load = 0;
   logic [5:0]   rst_i [6] = '{IDX_TX_CTRL, IDX_TX_DIAG, IDX_EVENT_ENABLE, IDX_EVENT_STATUS,
                               IDX_LABEL, IDX_LINE_PAR_LOW};

   slp_oh_monitor_regs DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_ev(rx_ev), .tx_in(tx_in), .tx_out(tx_out),
      .meter_load(meter_load), .irq(irq));
   slp_dp_model u_dp (.clk(clk), .rx_ev(rx_ev), .tx_in(tx_in));

   initial forever #5 clk = ~clk;
   always @(posedge clk)
   begin
      tx_q <= tx_in;
      if (meter_load === 1'b1) n_load++;
   end

   function automatic logic [7:0] ad(input logic [5:0] i);
      return {i, 2'b00};
   endfunction

   task automatic wrap_up;
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // pready, prdata and pslverr are taken at the rising edge itself
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] i, input logic [7:0] e);
      apb(1'b0, ad(i), 8'h00);
      `CHK($sformatf("reg %h", i), {24'h000000, e}, rdata)
      `CHK("pslverr", 1'b0, err)
   endtask

   task automatic settle;
      repeat (3) @(negedge clk);
   endtask

   initial
   begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rst_i[k]) rd(rst_i[k], 8'h00);
      `CHK("irq", 1'b0, irq)
      apb(1'b1, ad(IDX_TX_CTRL), 8'h01);
      apb(1'b1, ad(IDX_TX_DIAG), 8'h01);
      rd(IDX_TX_CTRL, 8'h01);
      rd(IDX_TX_DIAG, 8'h01);
      repeat (16)
      begin
         @(negedge clk);
         tx_e = tx_q;
         if (tx_e.k2_slot) tx_e.data[2:0] = 3'h6;
         if (tx_e.b2_slot) tx_e.data = ~tx_e.data;
         `CHK("tx_out", tx_e, tx_out)
      end
      apb(1'b0, 8'h3c, 8'h00);
      `CHK("refused", 33'h100000000, {err, rdata})
      apb(1'b1, ad(IDX_EVENT_ENABLE), 8'h02);
      u_dp.ev(4'h2, 1);
      settle();
      `CHK("irq", 1'b1, irq)
      rd(IDX_EVENT_STATUS, 8'h02);
      @(negedge clk);
      `CHK("irq", 1'b0, irq)
      u_dp.ev(4'h1, 1);
      settle();
      `CHK("irq", 1'b0, irq)
      rd(IDX_EVENT_STATUS, 8'h01);
      apb(1'b1, ad(IDX_EVENT_ENABLE), 8'had);
      u_dp.alarm(3'h7);
      settle();
      `CHK("irq", 1'b1, irq)
      rd(IDX_ALARM_STATUS, 8'h2c);
      rd(IDX_EVENT_STATUS, 8'h2c);
      u_dp.alarm(3'h0);
      settle();
      rd(IDX_EVENT_STATUS, 8'h2c);
      rd(IDX_EVENT_STATUS, 8'h00);
      rd(IDX_ALARM_STATUS, 8'h00);
      u_dp.frame(8'h13);
      u_dp.frame(8'h13);
      rd(IDX_LABEL, 8'h00);
      u_dp.frame(8'h13);
      settle();
      `CHK("irq", 1'b1, irq)
      rd(IDX_LABEL, 8'h13);
      rd(IDX_EVENT_STATUS, 8'h80);
      u_dp.ev(4'h8, 261);
      u_dp.ev(4'h4, 3);
      u_dp.ev(4'h2, 2);
      apb(1'b1, ad(IDX_LINE_PAR_LOW), 8'h00);
      settle();
      rd(IDX_LINE_PAR_LOW, 8'h05);
      rd(IDX_LINE_PAR_MID, 8'h01);
      rd(IDX_LINE_PAR_HIGH, 8'h00);
      rd(IDX_LINE_FAR_LOW, 8'h03);
      rd(IDX_LINE_FAR_MID, 8'h00);
      rd(IDX_LINE_FAR_HIGH, 8'h00);
      rd(IDX_PATH_PAR_LOW, 8'h00);
      u_dp.ev(4'h8, 1);
      apb(1'b1, ad(IDX_MASTER_LOAD), 8'h00);
      settle();
      `CHK("meter_load", 1, n_load)
      rd(IDX_PATH_PAR_LOW, 8'h03);
      rd(IDX_PATH_PAR_HIGH, 8'h00);
      rd(IDX_LINE_PAR_LOW, 8'h01);
      apb(1'b1, ad(IDX_LINE_FAR_HIGH), 8'h00);
      settle();
      rd(IDX_LINE_PAR_LOW, 8'h00);
      rd(IDX_LINE_FAR_LOW, 8'h00);
      wrap_up();
   end

   // whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
